// File: hdl/digipot_regs_pkg.sv
// Constants and carrier types for the volatile register bank of the digital potentiometer.
// Assumes a serial front end that decodes commands into single-cycle requests.
package digipot_regs_pkg;
  localparam int DATA_BITS = 9;
  localparam int ADDR_BITS = 4;
  localparam logic [3:0] ADDR_WIPER0 = 4'h0;
  localparam logic [3:0] ADDR_WIPER1 = 4'h1;
  localparam logic [3:0] ADDR_TERMINAL_CONNECT_CONTROL = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h5;
  localparam logic [8:0] TERMINAL_CONNECT_CONTROL_RESET = 9'h1FF;
  localparam logic [8:0] RESERVED_READ = 9'h000;
  localparam logic [3:0] STATUS_FIXED_ONES = 4'hF;
  localparam int STATUS_HW_POWERDOWN_PIN_BIT = 1;
  localparam int TERMINAL_CONNECT_CONTROL_FIXED_BIT = 8;
  localparam int NET1_LSB = 4;
  localparam int NET0_LSB = 0;
  localparam int FORCE_OFF_BIT = 3;
  localparam int END_A_BIT = 2;
  localparam int SLIDER_BIT = 1;
  localparam int END_B_BIT = 0;

  typedef enum logic [1:0] {
    OP_WRITE = 2'b00,
    OP_INCR = 2'b01,
    OP_DECR = 2'b10,
    OP_READ = 2'b11
  } op_t;

  typedef struct packed {
    logic valid;
    op_t op;
    logic [3:0] addr;
    logic [8:0] wdata;
  } cmd_t;

  typedef struct packed {
    logic end_a_on;
    logic slider_on;
    logic end_b_on;
    logic slider_to_b;
    logic [8:0] tap;
  } net_out_t;

  typedef struct packed {
    logic supply_seen;
    logic [8:0] wiper0;
    logic [8:0] wiper1;
    logic [8:0] terminal_connect_control;
    logic [7:0] applied;
    logic [8:0] rd_data;
    logic rd_valid;
    logic cmd_error;
    net_out_t net0;
    net_out_t net1;
  } bank_state_t;
endpackage

// File: hdl/digipot_register_bank.sv
// Volatile register bank and terminal connection control of a one- or two-network potentiometer.
// Assumes commands arrive already decoded, synchronous to clk_sys, and that cmd_end marks the
// end of each serial frame.
`timescale 1ns/1ps
module digipot_register_bank #(
  parameter int WIPER_BITS = 8,
  parameter bit DUAL = 1'b1
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic supply_ok,
  input wire logic hw_powerdown_pin_n,
  input wire digipot_regs_pkg::cmd_t cmd,
  input wire logic cmd_end,
  output logic [8:0] rd_data,
  output logic rd_valid,
  output logic cmd_error,
  output digipot_regs_pkg::net_out_t net0,
  output digipot_regs_pkg::net_out_t net1
);
  localparam logic [8:0] FULL_SCALE = 9'(1 << WIPER_BITS);
  localparam logic [8:0] MID_SCALE = 9'(1 << (WIPER_BITS - 1));

  digipot_regs_pkg::bank_state_t st;
  digipot_regs_pkg::bank_state_t next_st;

  // Values beyond full scale select terminal A
  function automatic logic [8:0] sat_tap(input logic [8:0] w);
    sat_tap = (w > FULL_SCALE) ? FULL_SCALE : w;
  endfunction

  function automatic digipot_regs_pkg::net_out_t net_cfg(input logic [3:0] ctl, input logic pin_active,
    input logic [8:0] w);
    digipot_regs_pkg::net_out_t n;
    n.tap = sat_tap(w);
    if (pin_active || !ctl[digipot_regs_pkg::FORCE_OFF_BIT])
    begin
      n.end_a_on = 1'b0;
      n.slider_on = 1'b1;
      n.end_b_on = 1'b1;
      n.slider_to_b = 1'b1;
    end
    else
    begin
      n.end_a_on = ctl[digipot_regs_pkg::END_A_BIT];
      n.slider_on = ctl[digipot_regs_pkg::SLIDER_BIT];
      n.end_b_on = ctl[digipot_regs_pkg::END_B_BIT];
      n.slider_to_b = 1'b0;
    end
    net_cfg = n;
  endfunction

  function automatic logic is_wiper(input logic [3:0] a);
    is_wiper = (a == digipot_regs_pkg::ADDR_WIPER0) || (DUAL && a == digipot_regs_pkg::ADDR_WIPER1);
  endfunction

  logic pin_active;
  logic [8:0] sel_wiper;
  logic [8:0] status_word;
  logic [8:0] rd_word;
  logic [8:0] new_wiper;

  always_comb
  begin
    pin_active = !hw_powerdown_pin_n;
    status_word = {digipot_regs_pkg::STATUS_FIXED_ONES, 3'b000, pin_active, 1'b0};
    sel_wiper = (cmd.addr == digipot_regs_pkg::ADDR_WIPER0) ? st.wiper0 : st.wiper1;
    new_wiper = sel_wiper;
    rd_word = digipot_regs_pkg::RESERVED_READ;
    if (is_wiper(cmd.addr))
    begin
      rd_word = sel_wiper;
    end
    else if (cmd.addr == digipot_regs_pkg::ADDR_TERMINAL_CONNECT_CONTROL)
    begin
      rd_word = st.terminal_connect_control;
    end
    else if (cmd.addr == digipot_regs_pkg::ADDR_STATUS)
    begin
      rd_word = status_word;
    end
    unique case (cmd.op)
      digipot_regs_pkg::OP_WRITE: new_wiper = cmd.wdata;
      digipot_regs_pkg::OP_INCR: new_wiper = (sel_wiper < FULL_SCALE) ? sel_wiper + 9'h001 : sel_wiper;
      digipot_regs_pkg::OP_DECR: new_wiper = (sel_wiper != 9'h000 && sel_wiper <= FULL_SCALE) ?
        sel_wiper - 9'h001 : sel_wiper;
      digipot_regs_pkg::OP_READ: new_wiper = sel_wiper;
    endcase

    next_st = st;
    next_st.supply_seen = supply_ok;
    next_st.rd_valid = 1'b0;
    next_st.cmd_error = 1'b0;
    if (supply_ok && !st.supply_seen)
    begin
      next_st.wiper0 = MID_SCALE;
      next_st.wiper1 = MID_SCALE;
      next_st.terminal_connect_control = digipot_regs_pkg::TERMINAL_CONNECT_CONTROL_RESET;
      next_st.applied = digipot_regs_pkg::TERMINAL_CONNECT_CONTROL_RESET[7:0];
    end
    else if (supply_ok && cmd.valid)
    begin
      if (cmd.op == digipot_regs_pkg::OP_READ)
      begin
        next_st.rd_data = rd_word;
        next_st.rd_valid = 1'b1;
      end
      else if (is_wiper(cmd.addr))
      begin
        if (cmd.addr == digipot_regs_pkg::ADDR_WIPER0)
        begin
          next_st.wiper0 = new_wiper;
        end
        else
        begin
          next_st.wiper1 = new_wiper;
        end
      end
      else if (cmd.addr == digipot_regs_pkg::ADDR_TERMINAL_CONNECT_CONTROL && cmd.op == digipot_regs_pkg::OP_WRITE)
      begin
        next_st.terminal_connect_control = {1'b1, cmd.wdata[7:0]};
      end
      else
      begin
        next_st.cmd_error = 1'b1;
      end
    end
    if (supply_ok && cmd_end && st.supply_seen)
    begin
      next_st.applied = next_st.terminal_connect_control[7:0];
    end
    next_st.net0 = net_cfg(st.applied[digipot_regs_pkg::NET0_LSB +: 4], pin_active, st.wiper0);
    next_st.net1 = DUAL ? net_cfg(st.applied[digipot_regs_pkg::NET1_LSB +: 4], pin_active, st.wiper1) :
      net_cfg(4'h0, 1'b1, 9'h000);
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '{supply_seen: 1'b0, wiper0: MID_SCALE, wiper1: MID_SCALE, terminal_connect_control: digipot_regs_pkg::TERMINAL_CONNECT_CONTROL_RESET,
        applied: 8'hFF, rd_data: 9'h000, rd_valid: 1'b0, cmd_error: 1'b0,
        net0: '{1'b1, 1'b1, 1'b1, 1'b0, MID_SCALE}, net1: '{1'b1, 1'b1, 1'b1, 1'b0, MID_SCALE}};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign rd_data = st.rd_data;
  assign rd_valid = st.rd_valid;
  assign cmd_error = st.cmd_error;
  assign net0 = st.net0;
  assign net1 = st.net1;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence seq_supply_rise;
    supply_ok && !st.supply_seen;
  endsequence

  sequence seq_status_read;
    supply_ok && st.supply_seen && cmd.valid && cmd.op == digipot_regs_pkg::OP_READ &&
      cmd.addr == digipot_regs_pkg::ADDR_STATUS;
  endsequence

  sequence seq_terminal_connect_control_write;
    supply_ok && st.supply_seen && cmd.valid && cmd.op == digipot_regs_pkg::OP_WRITE &&
      cmd.addr == digipot_regs_pkg::ADDR_TERMINAL_CONNECT_CONTROL;
  endsequence

  a_supply_defaults: assert property (seq_supply_rise |=> st.wiper0 == MID_SCALE && st.wiper1 == MID_SCALE)
    else $error("wiper not mid-scale after supply rise");
  a_terminal_connect_control_default: assert property (seq_supply_rise |=> st.terminal_connect_control == 9'h1FF)
    else $error("control not 1FFh after supply rise");
  a_serial_ignored: assert property (!supply_ok |=> !rd_valid && $stable(st.wiper0) && $stable(st.terminal_connect_control))
    else $error("serial request acted on below trip level");
  a_status_read: assert property (seq_status_read |=> rd_valid && rd_data[8:5] == 4'hF &&
    rd_data[1] == !$past(hw_powerdown_pin_n))
    else $error("status read wrong");
  a_terminal_connect_control_fixed: assert property (st.terminal_connect_control[8])
    else $error("control bit 8 not one");
  a_apply_hold: assert property (!cmd_end && st.supply_seen |=> $stable(st.applied))
    else $error("control applied before command end");
  a_pin_override: assert property (!hw_powerdown_pin_n ##1 !hw_powerdown_pin_n |->
    !net0.end_a_on && net0.slider_to_b && net0.slider_on && net0.end_b_on)
    else $error("shutdown configuration not shown");
  a_wiper_kept: assert property (seq_terminal_connect_control_write |=> $stable(st.wiper0) && $stable(st.wiper1))
    else $error("control write changed a wiper");
  a_tap_limit: assert property (net0.tap <= FULL_SCALE && net1.tap <= FULL_SCALE)
    else $error("tap above full scale");
  a_reserved_write: assert property (st.supply_seen && cmd.valid && cmd.op != digipot_regs_pkg::OP_READ &&
    cmd.addr > digipot_regs_pkg::ADDR_WIPER1 && cmd.addr != digipot_regs_pkg::ADDR_TERMINAL_CONNECT_CONTROL |=>
    $stable(st.wiper0) && $stable(st.wiper1) && $stable(st.terminal_connect_control))
    else $error("reserved write changed storage");

  // A request counts only with supply up outside its rising cycle
  sequence seq_taken;
    supply_ok && st.supply_seen && cmd.valid;
  endsequence

  sequence seq_read_taken;
    seq_taken ##0 cmd.op == digipot_regs_pkg::OP_READ;
  endsequence

  sequence seq_wiper0_cmd;
    seq_taken ##0 cmd.addr == digipot_regs_pkg::ADDR_WIPER0;
  endsequence

  sequence seq_wiper1_cmd;
    seq_taken ##0 DUAL && cmd.addr == digipot_regs_pkg::ADDR_WIPER1;
  endsequence

  sequence seq_refused_write;
    seq_taken ##0 cmd.op != digipot_regs_pkg::OP_READ && !is_wiper(cmd.addr) &&
      cmd.addr != digipot_regs_pkg::ADDR_TERMINAL_CONNECT_CONTROL;
  endsequence

  sequence seq_pin_low;
    !hw_powerdown_pin_n && st.supply_seen;
  endsequence

  a_read_answer: assert property (seq_read_taken |=> rd_valid)
    else $error("read not answered");

  a_read_quiet: assert property (!(cmd.valid && cmd.op == digipot_regs_pkg::OP_READ) |=>
    !rd_valid && $stable(st.rd_data))
    else $error("read data changed without a read");

  a_reserved_read: assert property (seq_read_taken ##0 (cmd.addr inside {4'h2, 4'h3} ||
    cmd.addr > digipot_regs_pkg::ADDR_STATUS) |=> rd_data == digipot_regs_pkg::RESERVED_READ)
    else $error("reserved location read not zero");

  a_status_zero: assert property (seq_status_read |=> rd_data[4:2] == 3'b000 && !rd_data[0])
    else $error("status reserved bits not zero");

  // Wiper arithmetic and its limits, control writes and the error flag
  a_wiper0_write: assert property (seq_wiper0_cmd ##0 cmd.op == digipot_regs_pkg::OP_WRITE |=>
    st.wiper0 == $past(cmd.wdata))
    else $error("wiper 0 write lost");

  a_wiper1_write: assert property (seq_wiper1_cmd ##0 cmd.op == digipot_regs_pkg::OP_WRITE |=>
    st.wiper1 == $past(cmd.wdata))
    else $error("wiper 1 write lost");

  a_incr_step: assert property (seq_wiper0_cmd ##0 cmd.op == digipot_regs_pkg::OP_INCR &&
    st.wiper0 < FULL_SCALE |=> st.wiper0 == $past(st.wiper0) + 9'h001)
    else $error("increment wrong");

  a_incr_ceiling: assert property (seq_wiper0_cmd ##0 cmd.op == digipot_regs_pkg::OP_INCR &&
    st.wiper0 >= FULL_SCALE |=> $stable(st.wiper0))
    else $error("increment past full scale");

  a_decr_step: assert property (seq_wiper0_cmd ##0 cmd.op == digipot_regs_pkg::OP_DECR &&
    st.wiper0 != 9'h000 && st.wiper0 <= FULL_SCALE |=> st.wiper0 == $past(st.wiper0) - 9'h001)
    else $error("decrement wrong");

  a_decr_floor: assert property (seq_wiper0_cmd ##0 cmd.op == digipot_regs_pkg::OP_DECR &&
    (st.wiper0 == 9'h000 || st.wiper0 > FULL_SCALE) |=> $stable(st.wiper0))
    else $error("decrement at limit moved wiper");

  a_incr1_step: assert property (seq_wiper1_cmd ##0 cmd.op == digipot_regs_pkg::OP_INCR &&
    st.wiper1 < FULL_SCALE |=> st.wiper1 == $past(st.wiper1) + 9'h001)
    else $error("increment wrong on wiper 1");

  a_incr1_ceiling: assert property (seq_wiper1_cmd ##0 cmd.op == digipot_regs_pkg::OP_INCR &&
    st.wiper1 >= FULL_SCALE |=> $stable(st.wiper1))
    else $error("increment past full scale on wiper 1");

  a_decr1_step: assert property (seq_wiper1_cmd ##0 cmd.op == digipot_regs_pkg::OP_DECR &&
    st.wiper1 != 9'h000 && st.wiper1 <= FULL_SCALE |=> st.wiper1 == $past(st.wiper1) - 9'h001)
    else $error("decrement wrong on wiper 1");

  a_decr1_floor: assert property (seq_wiper1_cmd ##0 cmd.op == digipot_regs_pkg::OP_DECR &&
    (st.wiper1 == 9'h000 || st.wiper1 > FULL_SCALE) |=> $stable(st.wiper1))
    else $error("decrement at limit moved wiper 1");

  a_terminal_connect_control_write: assert property (seq_terminal_connect_control_write |=>
    st.terminal_connect_control == {1'b1, $past(cmd.wdata[7:0])})
    else $error("control write lost");

  a_terminal_connect_control_step_refused: assert property (seq_taken ##0 cmd.addr == digipot_regs_pkg::ADDR_TERMINAL_CONNECT_CONTROL &&
    cmd.op inside {digipot_regs_pkg::OP_INCR, digipot_regs_pkg::OP_DECR} |=> cmd_error && $stable(st.terminal_connect_control))
    else $error("step on control not refused");

  a_refused_error: assert property (seq_refused_write |=> cmd_error)
    else $error("refused write not flagged");

  a_error_quiet: assert property (!cmd.valid |=> !cmd_error)
    else $error("error flag without a request");

  a_serial_error: assert property (!supply_ok |=>
    !cmd_error && $stable(st.wiper1) && $stable(st.rd_data))
    else $error("request flagged below trip level");

  // Terminal configuration
  a_supply_apply: assert property (seq_supply_rise |=>
    st.applied == digipot_regs_pkg::TERMINAL_CONNECT_CONTROL_RESET[7:0])
    else $error("terminals not connected after supply rise");

  a_apply_latch: assert property (supply_ok && st.supply_seen && cmd_end |=>
    st.applied == st.terminal_connect_control[7:0])
    else $error("control not applied at command end");

  a_force_off: assert property (
    !st.applied[digipot_regs_pkg::NET0_LSB + digipot_regs_pkg::FORCE_OFF_BIT] |=>
    !net0.end_a_on && net0.slider_to_b)
    else $error("force-off bit did not force shutdown");

  a_net1_force: assert property (
    DUAL && !st.applied[digipot_regs_pkg::NET1_LSB + digipot_regs_pkg::FORCE_OFF_BIT] |=>
    !net1.end_a_on && net1.slider_to_b)
    else $error("force-off bit did not force network 1");

  a_connect_follow: assert property (
    hw_powerdown_pin_n && st.applied[digipot_regs_pkg::FORCE_OFF_BIT] |=>
    net0.end_a_on == $past(st.applied[digipot_regs_pkg::END_A_BIT]) &&
    net0.slider_on == $past(st.applied[digipot_regs_pkg::SLIDER_BIT]) &&
    net0.end_b_on == $past(st.applied[digipot_regs_pkg::END_B_BIT]) && !net0.slider_to_b)
    else $error("connect bits not shown on network 0");

  a_net1_connect: assert property (
    DUAL && hw_powerdown_pin_n && st.applied[digipot_regs_pkg::NET1_LSB + digipot_regs_pkg::FORCE_OFF_BIT] |=>
    net1.end_a_on == $past(st.applied[digipot_regs_pkg::NET1_LSB + digipot_regs_pkg::END_A_BIT]) &&
    net1.slider_on == $past(st.applied[digipot_regs_pkg::NET1_LSB + digipot_regs_pkg::SLIDER_BIT]) &&
    net1.end_b_on == $past(st.applied[digipot_regs_pkg::NET1_LSB + digipot_regs_pkg::END_B_BIT]) &&
    !net1.slider_to_b)
    else $error("connect bits not shown on network 1");

  a_pin_keeps_terminal_connect_control: assert property (seq_pin_low ##0 !(cmd.valid &&
    cmd.op == digipot_regs_pkg::OP_WRITE && cmd.addr == digipot_regs_pkg::ADDR_TERMINAL_CONNECT_CONTROL) |=> $stable(st.terminal_connect_control))
    else $error("shutdown pin altered control bits");

  a_pin_net1: assert property (!hw_powerdown_pin_n |=>
    !net1.end_a_on && net1.slider_on && net1.end_b_on && net1.slider_to_b)
    else $error("network 1 not in shutdown form");

  a_tap_follow: assert property (st.wiper0 <= FULL_SCALE |=> net0.tap == $past(st.wiper0))
    else $error("tap does not follow wiper 0");

  a_tap_saturate: assert property (st.wiper0 > FULL_SCALE |=> net0.tap == FULL_SCALE)
    else $error("tap above full scale not saturated");

  a_net1_tap: assert property (DUAL && st.wiper1 <= FULL_SCALE |=> net1.tap == $past(st.wiper1))
    else $error("tap does not follow wiper 1");
endmodule

// File: verification/digipot_host_model.sv
// Host controller model issuing decoded register commands.
// Assumes the bank takes a request at the rising edge and answers one cycle later.
`timescale 1ns/1ps
module digipot_host_model (
  input wire logic clk_sys,
  input wire logic rd_valid,
  input wire logic cmd_error,
  input wire logic [8:0] rd_data,
  output digipot_regs_pkg::cmd_t cmd,
  output logic cmd_end
);
  initial
  begin
    cmd = '0;
    cmd_end = 1'b0;
  end
  // Result sampled at the falling edge after the taking edge, while the one-cycle flags stand
  task automatic xfer(input digipot_regs_pkg::op_t op, input logic [3:0] a, input logic [8:0] v,
    input logic fin, output logic [8:0] rdat, output logic [1:0] flags);
    @(negedge clk_sys);
    cmd = '{valid: 1'b1, op: op, addr: a, wdata: v};
    cmd_end = fin;
    @(negedge clk_sys);
    rdat = rd_data;
    flags = {rd_valid, cmd_error};
    cmd = '0;
    cmd_end = 1'b0;
  endtask
  task automatic restore();
    logic [8:0] d;
    logic [1:0] f;
    xfer(digipot_regs_pkg::OP_WRITE, 4'h4, 9'h1FF, 1'b1, d, f);
  endtask
endmodule

// File: verification/digipot_register_bank_tb.sv
// Self-checking bench for the volatile register bank.
// Assumes the host model drives all command inputs.
`timescale 1ns/1ps
module digipot_register_bank_tb;
  logic clk_sys;
  logic rst_n;
  logic supply_ok;
  logic hw_powerdown_pin_n;
  digipot_regs_pkg::cmd_t cmd;
  logic cmd_end;
  logic [8:0] rd_data;
  logic rd_valid;
  logic cmd_error;
  digipot_regs_pkg::net_out_t net0;
  digipot_regs_pkg::net_out_t net1;
  int fails;
  int n_compared;
  logic [8:0] d;
  logic [1:0] f;
  digipot_register_bank #(.WIPER_BITS(8), .DUAL(1'b1)) digipot_register_bank_i (.clk_sys(clk_sys),
    .rst_n(rst_n), .supply_ok(supply_ok), .hw_powerdown_pin_n(hw_powerdown_pin_n), .cmd(cmd),
    .cmd_end(cmd_end), .rd_data(rd_data), .rd_valid(rd_valid), .cmd_error(cmd_error),
    .net0(net0), .net1(net1));
  digipot_host_model digipot_host_model_i (.clk_sys(clk_sys), .rd_valid(rd_valid),
    .cmd_error(cmd_error), .rd_data(rd_data), .cmd(cmd), .cmd_end(cmd_end));
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp, input string what);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic op(input digipot_regs_pkg::op_t o, input logic [3:0] a, input logic [8:0] v,
    input logic fin, input logic e);
    digipot_host_model_i.xfer(o, a, v, fin, d, f);
    chk({8'h00, f[0]}, {8'h00, e}, "error flag");
  endtask
  task automatic rd(input logic [3:0] a, input logic [8:0] exp);
    digipot_host_model_i.xfer(digipot_regs_pkg::OP_READ, a, 9'h000, 1'b0, d, f);
    chk(d, exp, "read data");
    chk({7'h00, f}, 9'h002, "read flags");
  endtask
  // Terminal state as {end_a, slider, end_b, slider_to_b}
  function automatic logic [8:0] nb(input digipot_regs_pkg::net_out_t n);
    return {5'h00, n.end_a_on, n.slider_on, n.end_b_on, n.slider_to_b};
  endfunction
  task automatic settle();
    repeat (3) @(negedge clk_sys);
  endtask
  task automatic t_reset();
    rd(4'h0, 9'h080);
    rd(4'h1, 9'h080);
    rd(4'h4, 9'h1FF);
    rd(4'h5, 9'h1E0);
    chk(nb(net0), 9'h00E, "net0 reset");
    $display("test reset done");
  endtask
  task automatic t_terminal_connect_control();
    op(digipot_regs_pkg::OP_WRITE, 4'h4, 9'h0F0, 1'b0, 1'b0);
    rd(4'h4, 9'h1F0);
    chk(nb(net0), 9'h00E, "before frame end");
    digipot_host_model_i.xfer(digipot_regs_pkg::OP_READ, 4'h0, 9'h000, 1'b1, d, f);
    chk(d, 9'h080, "wiper kept");
    settle();
    chk({7'h00, net0.end_a_on, net0.slider_to_b}, 9'h001, "net0 forced");
    chk(nb(net1), 9'h00E, "net1 free");
    digipot_host_model_i.restore();
    $display("test control done");
  endtask
  task automatic t_connect();
    op(digipot_regs_pkg::OP_WRITE, 4'h4, 9'h1FA, 1'b1, 1'b0);
    settle();
    chk(nb(net0), 9'h004, "connect bits");
    hw_powerdown_pin_n = 1'b0;
    settle();
    chk({7'h00, net0.end_a_on, net0.slider_to_b}, 9'h001, "pin shutdown");
    chk({7'h00, net1.end_a_on, net1.slider_to_b}, 9'h001, "pin net1");
    rd(4'h5, 9'h1E2);
    rd(4'h4, 9'h1FA);
    hw_powerdown_pin_n = 1'b1;
    settle();
    chk(nb(net0), 9'h004, "pin released");
    digipot_host_model_i.restore();
    $display("test connect done");
  endtask
  task automatic t_wiper();
    op(digipot_regs_pkg::OP_WRITE, 4'h0, 9'h100, 1'b0, 1'b0);
    op(digipot_regs_pkg::OP_INCR, 4'h0, 9'h000, 1'b0, 1'b0);
    rd(4'h0, 9'h100);
    op(digipot_regs_pkg::OP_WRITE, 4'h1, 9'h000, 1'b0, 1'b0);
    op(digipot_regs_pkg::OP_DECR, 4'h1, 9'h000, 1'b0, 1'b0);
    rd(4'h1, 9'h000);
    op(digipot_regs_pkg::OP_INCR, 4'h1, 9'h000, 1'b0, 1'b0);
    rd(4'h1, 9'h001);
    op(digipot_regs_pkg::OP_WRITE, 4'h2, 9'h055, 1'b0, 1'b1);
    op(digipot_regs_pkg::OP_WRITE, 4'h5, 9'h055, 1'b0, 1'b1);
    op(digipot_regs_pkg::OP_WRITE, 4'hF, 9'h055, 1'b0, 1'b1);
    rd(4'h2, 9'h000);
    rd(4'h0, 9'h100);
    rd(4'h5, 9'h1E0);
    op(digipot_regs_pkg::OP_INCR, 4'h4, 9'h000, 1'b0, 1'b1);
    rd(4'h4, 9'h1FF);
    op(digipot_regs_pkg::OP_WRITE, 4'h0, 9'h1FF, 1'b0, 1'b0);
    op(digipot_regs_pkg::OP_DECR, 4'h0, 9'h000, 1'b0, 1'b0);
    rd(4'h0, 9'h1FF);
    settle();
    chk(net0.tap, 9'h100, "tap full scale");
    chk(net1.tap, 9'h001, "tap net1");
    $display("test wiper done");
  endtask
  task automatic t_supply();
    op(digipot_regs_pkg::OP_WRITE, 4'h4, 9'h0F0, 1'b1, 1'b0);
    @(negedge clk_sys);
    supply_ok = 1'b0;
    digipot_host_model_i.xfer(digipot_regs_pkg::OP_READ, 4'h0, 9'h000, 1'b0, d, f);
    chk({7'h00, f}, 9'h000, "ignored read");
    supply_ok = 1'b1;
    repeat (2) @(negedge clk_sys);
    rd(4'h0, 9'h080);
    rd(4'h1, 9'h080);
    rd(4'h4, 9'h1FF);
    chk(nb(net0), 9'h00E, "net0 after supply");
    digipot_host_model_i.restore();
    $display("test supply done");
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    fails = 0;
    n_compared = 0;
    rst_n = 1'b0;
    supply_ok = 1'b1;
    hw_powerdown_pin_n = 1'b1;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (2) @(negedge clk_sys);
    t_reset();
    t_terminal_connect_control();
    t_connect();
    t_wiper();
    t_supply();
    report_and_stop();
  end
  initial
  begin
    #200000;
    fails++;
    report_and_stop();
  end
endmodule
